// file: frl_ramp_limiter.sv
// fan pwm ramp limiter: apb register file, thermal alarm capture of
// operating points, and four slew-limited pwm channels.
// assumes the fan loop on core_clk delivers duty targets with a pulse
// per channel and remote temperatures as steady words.
//
// How it works
// [R1] dynamic start-temperature register bits 5..2 arm per-channel capture.
// [R2] armed channel copies its remote temperature into operating point on alarm.
// [R3] unarmed channel ignores alarm; operating point keeps software value.
// [R4] smoothing off: computed duty goes to output at once.
// [R5] smoothing on: duty change per update bounded by selected step.
// [R6] acoustic register a bit 0 smooths channel a, bit 1 channel b.
// [R7] acoustic register b bit 0 smooths channel c, bit 1 channel d.
// [R8] each channel chooses smoothing independently of the others.
// [R9] pwm period has 255 slots; one slot is the smallest increment.
// [R10] target above applied duty: add the selected step of 1 to 48.
// [R11] target below applied duty: subtract the selected step.
// [R12] result of each step is stored as the next comparison base.
// [R13] step code 000..111 means 1,2,3,5,8,12,24,48 slots.
// [R14] channel b step code sits in acoustic register a bits 7..5.
// [R15] full ramp lasts about 35 s at step 1, 0.8 s at step 48.
// [R16] channel c step code sits in acoustic register b bits 4..2.
// [R17] channel d step code sits in acoustic register b bits 7..5.
// [R18] step clamps at target, never overshoots; equal values stay put.
// [R19] one step per channel per new computed duty from the loop.
//
// Implementation choice: register access over APB.

`timescale 1ns/1ns
`default_nettype none

module frl_ramp_limiter
  import frl_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int SLOT_DIV = 16
)
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // fan loop side
  input  wire logic [3:0]        duty_update,
  input  wire logic [3:0][7:0]   duty_target,
  input  wire logic [3:0][7:0]   remote_temp,
  output logic      [3:0][7:0]   op_point,
  output logic      [3:0][7:0]   applied_duty,
  // pins
  input  wire logic              thermal_alarm_input_n,
  output logic      [3:0]        pwm_out
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 10 || ADDR_W > 16)
    $error("frl_ramp_limiter: ADDR_W must lie in 10..16");
  if (SLOT_DIV < 1 || SLOT_DIV > 65535)
    $error("frl_ramp_limiter: SLOT_DIV must lie in 1..65535");

  // ------------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------------
  logic [7:0] dyn_start_temp_control_1;
  logic [7:0] acoustic_smoothing_ctrl_a;
  logic [7:0] acoustic_smoothing_ctrl_b;

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  logic [ADDR_W-3:0] idx;
  logic              aligned;
  logic              hit_dyn;
  logic              hit_aca;
  logic              hit_acb;
  logic              hit_op;
  logic              hit_duty;
  logic              mapped;
  logic [1:0]        sub;
  logic              setup_ph;
  logic              wr_take;
  logic [7:0]        rd_byte;
  logic [7:0]        wbyte;

  assign idx      = paddr[ADDR_W-1:2];
  assign aligned  = (paddr[1:0] == 2'b00);
  assign sub      = idx[1:0];
  assign hit_dyn  = aligned && (idx == (ADDR_W-2)'(FRL_IDX_DYN_START));
  assign hit_aca  = aligned && (idx == (ADDR_W-2)'(FRL_IDX_ACOU_A));
  assign hit_acb  = aligned && (idx == (ADDR_W-2)'(FRL_IDX_ACOU_B));
  assign hit_op   = aligned &&
                    (idx[ADDR_W-3:2] == (ADDR_W-4)'(FRL_IDX_OPPT_BASE >> 2));
  assign hit_duty = aligned &&
                    (idx[ADDR_W-3:2] == (ADDR_W-4)'(FRL_IDX_DUTY_BASE >> 2));
  assign mapped   = hit_dyn || hit_aca || hit_acb || hit_op || hit_duty;

  assign setup_ph = psel && !penable;
  // zero wait states: every access phase completes at once
  assign pready   = 1'b1;
  assign wr_take  = psel && penable && pready && pwrite && pstrb[0];
  assign wbyte    = pwdata[7:0];

  assign rd_byte  = hit_dyn  ? dyn_start_temp_control_1  :
                    hit_aca  ? acoustic_smoothing_ctrl_a :
                    hit_acb  ? acoustic_smoothing_ctrl_b :
                    hit_op   ? op_point[sub]             :
                    hit_duty ? applied_duty[sub]         :
                    8'h00;

  // read data and error are caught in the setup cycle so that both
  // leave flip-flops during the access phase
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setup_ph)
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pslverr <= 1'b0;
    else if (setup_ph)
      pslverr <= !mapped;
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dyn_start_temp_control_1 <= FRL_RST_REG;
    else if (wr_take && hit_dyn)
      dyn_start_temp_control_1 <= wbyte;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      acoustic_smoothing_ctrl_a <= FRL_RST_REG;
    else if (wr_take && hit_aca)
      acoustic_smoothing_ctrl_a <= wbyte;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      acoustic_smoothing_ctrl_b <= FRL_RST_REG;
    else if (wr_take && hit_acb)
      acoustic_smoothing_ctrl_b <= wbyte;
  end

  // ------------------------------------------------------------------
  // per-channel field split
  // ------------------------------------------------------------------
  logic [3:0]      smooth_en;
  logic [3:0][2:0] step_sel;
  logic [3:0]      capture_arm;

  // each output carries its own enable, so two outputs fed from one
  // temperature can ramp differently
  assign smooth_en[0] = acoustic_smoothing_ctrl_a[FRL_EN_LO_BIT]; // [R6] [R8]
  assign smooth_en[1] = acoustic_smoothing_ctrl_a[FRL_EN_HI_BIT]; // [R6] [R8]
  assign smooth_en[2] = acoustic_smoothing_ctrl_b[FRL_EN_LO_BIT]; // [R7] [R8]
  assign smooth_en[3] = acoustic_smoothing_ctrl_b[FRL_EN_HI_BIT]; // [R7] [R8]

  assign step_sel[0] =
    acoustic_smoothing_ctrl_a[FRL_STEP_LO_LSB +: FRL_STEP_W];     // [R13]
  assign step_sel[1] =
    acoustic_smoothing_ctrl_a[FRL_STEP_HI_LSB +: FRL_STEP_W];     // [R14]
  assign step_sel[2] =
    acoustic_smoothing_ctrl_b[FRL_STEP_LO_LSB +: FRL_STEP_W];     // [R16]
  assign step_sel[3] =
    acoustic_smoothing_ctrl_b[FRL_STEP_HI_LSB +: FRL_STEP_W];     // [R17]

  assign capture_arm =
    dyn_start_temp_control_1[FRL_ARM_LSB +: FRL_NCH];             // [R1]

  // ------------------------------------------------------------------
  // thermal alarm synchroniser and assertion edge
  // ------------------------------------------------------------------
  logic alarm_meta;
  logic alarm_sync;
  logic alarm_prev;
  logic alarm_rise;

  // pin is active low and idles high
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      alarm_meta <= 1'b1;
      alarm_sync <= 1'b1;
      alarm_prev <= 1'b1;
    end
    else
    begin
      alarm_meta <= thermal_alarm_input_n;
      alarm_sync <= alarm_meta;
      alarm_prev <= alarm_sync;
    end
  end

  // only the assertion edge captures, so a held alarm does not keep
  // overwriting the value software may write later
  assign alarm_rise = alarm_prev && !alarm_sync;

  // ------------------------------------------------------------------
  // operating-point registers
  // ------------------------------------------------------------------
  logic [3:0] op_capture;
  logic [3:0] op_write;
  logic [7:0] slot;

  assign op_capture = {FRL_NCH{alarm_rise}} & capture_arm;        // [R2] [R3]

  genvar ch;
  for (ch = 0; ch < FRL_NCH; ch++)
  begin : g_ch
    assign op_write[ch] = wr_take && hit_op && (sub == 2'(ch));

    // hardware capture wins over a software write in the same cycle
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        op_point[ch] <= FRL_RST_REG;
      else if (op_capture[ch])
        op_point[ch] <= remote_temp[ch];                           // [R2]
      else if (op_write[ch])
        op_point[ch] <= wbyte;                                     // [R3]
    end

    frl_slew u_slew (
      .core_clk  (core_clk),
      .rst       (rst),
      .update    (duty_update[ch]),
      .smooth_en (smooth_en[ch]),
      .step_sel  (step_sel[ch]),
      .target    (duty_target[ch]),
      .slot      (slot),
      .duty      (applied_duty[ch]),
      .pwm_out   (pwm_out[ch])
    );                                                             // [R5]
  end

  // ------------------------------------------------------------------
  // pwm slot timing
  // ------------------------------------------------------------------
  // ramp duration follows the loop update rate: 255 updates at step 1
  // give the full-scale time, so the loop period sets it
  logic [15:0] slot_div_cnt;
  logic        slot_tick;

  assign slot_tick = (slot_div_cnt == 16'(SLOT_DIV - 1));

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      slot_div_cnt <= 16'h0000;
    else if (slot_tick)
      slot_div_cnt <= 16'h0000;
    else
      slot_div_cnt <= slot_div_cnt + 16'h0001;
  end

  // slots run 0..254, 255 per period
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      slot <= 8'h00;
    else if (slot_tick)
      slot <= (slot == FRL_SLOT_LAST) ? 8'h00 : slot + 8'h01;     // [R9]
  end

  // ------------------------------------------------------------------
  // ramp time reference
  // ------------------------------------------------------------------
  // update period in us needed so 255 single-slot steps span the slow ramp;
  // exported only for integration checks
  localparam int RAMP_UPDATE_US = (FRL_RAMP_SLOW_MS * 1000) / 255; // [R15]

endmodule // frl_ramp_limiter

`default_nettype wire

// file: frl_pkg.sv
// shared constants of the fan ramp limiter: register indices, fields,
// reset values and the step table.
// assumes apb byte addressing with one 32-bit word per register index.

package frl_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [7:0] FRL_IDX_DYN_START = 8'h0b;
  localparam logic [7:0] FRL_IDX_ACOU_A    = 8'h1a;
  localparam logic [7:0] FRL_IDX_ACOU_B    = 8'h1b;
  localparam logic [7:0] FRL_IDX_OPPT_BASE = 8'h20;
  localparam logic [7:0] FRL_IDX_DUTY_BASE = 8'h28;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] FRL_RST_REG  = 8'h00;
  localparam logic [7:0] FRL_RST_DUTY = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int FRL_NCH        = 4;
  localparam int FRL_ARM_LSB    = 2;
  localparam int FRL_EN_LO_BIT  = 0;
  localparam int FRL_EN_HI_BIT  = 1;
  localparam int FRL_STEP_LO_LSB = 2;
  localparam int FRL_STEP_HI_LSB = 5;
  localparam int FRL_STEP_W     = 3;

  // ------------------------------------------------------------------
  // pwm slots and ramp steps
  // ------------------------------------------------------------------
  localparam logic [7:0] FRL_SLOT_LAST = 8'hfe;
  localparam logic [7:0] FRL_STEP_TAB [8] = '{
    8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30
  };

  // full-scale ramp times at the smallest and largest step, in ms
  localparam int FRL_RAMP_SLOW_MS = 35000;
  localparam int FRL_RAMP_FAST_MS = 800;

endpackage

// file: frl_slew.sv
// one pwm channel: duty slew limiter and 255-slot pwm comparator.
// assumes update is a one-cycle pulse from logic on core_clk.

`timescale 1ns/1ns
`default_nettype none

module frl_slew
  import frl_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // control
  input  wire logic       update,
  input  wire logic       smooth_en,
  input  wire logic [2:0] step_sel,
  input  wire logic [7:0] target,
  input  wire logic [7:0] slot,
  // outputs
  output logic      [7:0] duty,
  output logic            pwm_out
);

  logic [7:0] step;
  logic [7:0] gap_up;
  logic [7:0] gap_dn;
  logic [7:0] next_duty;

  assign step   = FRL_STEP_TAB[step_sel];                      // [R13]
  assign gap_up = target - duty;
  assign gap_dn = duty - target;

  always_comb
  begin
    next_duty = duty;
    if (update)                                                // [R19]
    begin
      if (!smooth_en)
        next_duty = target;                                    // [R4]
      else if (target > duty)
        next_duty = (gap_up > step) ? duty + step : target;    // [R10]
      else if (target < duty)
        next_duty = (gap_dn > step) ? duty - step : target;    // [R11]
      else
        next_duty = duty;                                      // [R18]
    end
  end

  // the stored value is the base of the next comparison
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      duty <= FRL_RST_DUTY;
    else
      duty <= next_duty;                                       // [R12]
  end

  // duty of 255 keeps the output high through all slots 0..254
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pwm_out <= 1'b0;
    else
      pwm_out <= (slot < duty);                                // [R9]
  end

endmodule // frl_slew

`default_nettype wire

// file: frl_ramp_limiter_properties.sv
// expectation helpers and concurrent checks for the ramp limiter.
// assumes apb byte addresses equal to four times the register index.
`timescale 1ns/1ns
`default_nettype none

package frl_expect_pkg;
  localparam logic [11:0] A_DYN = 12'h02c;
  localparam logic [11:0] A_ACA = 12'h068;
  localparam logic [11:0] A_ACB = 12'h06c;
  localparam logic [11:0] A_OPP = 12'h080;
  localparam logic [11:0] A_DUT = 12'h0a0;
  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code)
      3'h0: return 8'h01;
      3'h1: return 8'h02;
      3'h2: return 8'h03;
      3'h3: return 8'h05;
      3'h4: return 8'h08;
      3'h5: return 8'h0c;
      3'h6: return 8'h18;
      default: return 8'h30;
    endcase
  endfunction
  function automatic logic en_of(input logic [7:0] a, b, input int c);
    return (c < 2) ? a[c] : b[c-2];
  endfunction
  function automatic logic [2:0] code_of(input logic [7:0] a, b,
                                         input int c);
    return c == 0 ? a[4:2] : c == 1 ? a[7:5] : c == 2 ? b[4:2] : b[7:5];
  endfunction
  function automatic logic [7:0] next_duty(input logic [7:0] p, t,
                                           input logic e,
                                           input logic [2:0] code);
    logic [7:0] s;
    s = step_of(code);
    if (!e) return t;
    if (t > p) return (t - p > s) ? p + s : t;
    if (t < p) return (p - t > s) ? p - s : t;
    return p;
  endfunction
endpackage

module frl_ramp_limiter_properties
  import frl_expect_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int SLOT_DIV = 16
)
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              rst,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  // loop side and pins
  input wire logic [3:0]        duty_update,
  input wire logic [3:0][7:0]   duty_target,
  input wire logic [3:0][7:0]   remote_temp,
  input wire logic [3:0][7:0]   op_point,
  input wire logic [3:0][7:0]   applied_duty,
  input wire logic              thermal_alarm_input_n,
  input wire logic [3:0]        pwm_out
);
  logic [7:0]      dyn, aca, acb;
  logic [3:0]      en, arm;
  logic [3:0][7:0] nxt;
  wire logic       wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  // shadow of the control registers, updated on the apb write edge
  always_ff @(posedge core_clk or posedge rst)
    if (rst) {dyn, aca, acb} <= '0;
    else if (wr && paddr == ADDR_W'(A_DYN)) dyn <= pwdata[7:0];
    else if (wr && paddr == ADDR_W'(A_ACA)) aca <= pwdata[7:0];
    else if (wr && paddr == ADDR_W'(A_ACB)) acb <= pwdata[7:0];
  always_comb
    for (int c = 0; c < 4; c++)
    begin
      en[c]  = en_of(aca, acb, c);
      arm[c] = dyn[2+c];
      nxt[c] = next_duty(applied_duty[c], duty_target[c], en[c],
                         code_of(aca, acb, c));
    end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  for (genvar c = 0; c < 4; c++)
  begin : g_ch
    sequence alarm_s;
      $fell(thermal_alarm_input_n);
    endsequence
    slew_next_a: assert property (
      duty_update[c] |=> applied_duty[c] == $past(nxt[c]))
      else $error("applied duty differs from the expected step");
    bypass_a: assert property (
      duty_update[c] && !en[c] |=> applied_duty[c] == $past(duty_target[c]))
      else $error("unsmoothed duty did not follow target");
    duty_hold_a: assert property (
      !duty_update[c] |=> $stable(applied_duty[c]))
      else $error("duty moved without an update");
    step_bound_a: assert property (
      duty_update[c] && en[c] |=>
        8'(applied_duty[c] - $past(applied_duty[c]) + 8'd48) <= 8'd96)
      else $error("smoothed duty moved more than the largest step");
    alarm_capture_a: assert property (
      alarm_s ##0 arm[c] |-> ##[1:4] op_point[c] == remote_temp[c])
      else $error("armed operating point not captured");
    alarm_ignore_a: assert property (
      alarm_s ##0 !arm[c] |=> ($stable(op_point[c]))[*5])
      else $error("unarmed operating point changed on alarm");
    pwm_off_a: assert property (
      (applied_duty[c] == 8'h00)[*2] |-> !pwm_out[c])
      else $error("pwm high at zero duty");
    pwm_full_a: assert property (
      (applied_duty[c] == 8'hff)[*2] |-> pwm_out[c])
      else $error("pwm low at full duty");
  end
endmodule // frl_ramp_limiter_properties

bind frl_ramp_limiter frl_ramp_limiter_properties #(
  .ADDR_W(ADDR_W), .SLOT_DIV(SLOT_DIV)) frl_props_i (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .duty_update(duty_update), .duty_target(duty_target),
  .remote_temp(remote_temp), .op_point(op_point),
  .applied_duty(applied_duty), .pwm_out(pwm_out),
  .thermal_alarm_input_n(thermal_alarm_input_n));
`default_nettype wire

// file: frl_fan_model.sv
// fan drive stage model: counts pwm high cycles over each pwm period.
// assumes one pwm slot per clock, so a period is 255 clocks.
`timescale 1ns/1ns
`default_nettype none

module frl_fan_model
#(
  parameter int PERIOD = 255
)
(
  // clock and reset
  input  wire logic      core_clk,
  input  wire logic      rst,
  // pwm pins from the device
  input  wire logic [3:0] pwm,
  // high time of the last full period, per fan
  output logic [3:0][7:0] hi_cnt
);
  int              phase;
  logic [3:0][8:0] acc;
  // window is not aligned to the device period; steady duty gives same sum
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      phase  <= 0;
      acc    <= '0;
      hi_cnt <= '0;
    end
    else
    begin
      phase <= (phase == PERIOD - 1) ? 0 : phase + 1;
      for (int c = 0; c < 4; c++)
        if (phase == PERIOD - 1)
        begin
          hi_cnt[c] <= 8'(acc[c] + 9'(pwm[c]));
          acc[c]    <= '0;
        end
        else acc[c] <= acc[c] + 9'(pwm[c]);
    end
endmodule // frl_fan_model
`default_nettype wire

// file: frl_ramp_limiter_tb.sv
// self-checking bench for the ramp limiter with a fan stage model.
// assumes zero-wait apb and one pwm slot per clock.
`timescale 1ns/1ns
`default_nettype none

module frl_ramp_limiter_tb;
  import frl_expect_pkg::*;
  logic            core_clk, rst, psel, penable, pwrite, alarm_n;
  logic            pready, pslverr, er;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      pstrb, duty_update, pwm_out;
  logic [3:0][7:0] duty_target, remote_temp, op_point, applied_duty;
  logic [3:0][7:0] hi_cnt;
  logic [7:0]      exp_duty [4];
  logic [7:0]      opv [4];
  logic [7:0]      aca, acb, v, arm;
  int              mismatches, num_checks;
  int              fast;

  frl_ramp_limiter #(.ADDR_W(12), .SLOT_DIV(1)) frl_ramp_limiter_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .duty_update(duty_update), .duty_target(duty_target),
    .remote_temp(remote_temp), .op_point(op_point),
    .applied_duty(applied_duty), .pwm_out(pwm_out),
    .thermal_alarm_input_n(alarm_n));
  frl_fan_model #(.PERIOD(255)) frl_fan_model_i (
    .core_clk(core_clk), .rst(rst), .pwm(pwm_out), .hi_cnt(hi_cnt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // one pulse on all channels; target word changes freely between pulses
  task automatic update(input logic [3:0][7:0] t);
    @(posedge core_clk);
    duty_update <= 4'hf;
    duty_target <= t;
    @(posedge core_clk);
    duty_update <= 4'h0;
    duty_target <= $urandom;
    for (int c = 0; c < 4; c++)
      exp_duty[c] = next_duty(exp_duty[c], t[c], en_of(aca, acb, c),
                              code_of(aca, acb, c));
    @(posedge core_clk);
    for (int c = 0; c < 4; c++)
      chk(applied_duty[c], exp_duty[c]);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end
  initial
  begin
    {rst, alarm_n, pstrb} = 6'h3f;
    {psel, penable, pwrite, paddr, pwdata, duty_update} = '0;
    {duty_target, remote_temp, aca, acb} = '0;
    exp_duty = '{default: 8'h00};
    rd = $urandom(14);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    foreach (exp_duty[i])
    begin
      v = $urandom;
      // the last pass reads an operating point, still at its reset value
      apb(0, i == 0 ? A_DYN : i == 1 ? A_ACA : i == 2 ? A_ACB : A_OPP,
          8'h00);
      chk(rd, 32'h0);
      apb(1, paddr, v);
      apb(0, paddr, 8'h00);
      chk(rd, {24'h0, v});
      if (i == 3) apb(0, 12'h04c, 8'h00);
      if (i == 3) chk({rd[30:0], er}, 32'h1);
    end
    for (int k = 0; k < 8; k++)
    begin
      aca = {3'(k), 3'(k), 2'b11};
      // odd passes smooth channel d and leave c unsmoothed, even the reverse
      acb = {3'(7 - k), 3'(k), k[0], !k[0]};
      apb(1, A_ACA, aca);
      apb(1, A_ACB, acb);
      update({exp_duty[3], exp_duty[2], exp_duty[1], exp_duty[0]});
      update({4{8'hff}});
      update('0);
      repeat (3) update($urandom);
    end
    apb(1, A_DUT, 8'h5a);
    apb(0, A_DUT, 8'h00);
    chk(rd, {24'h0, exp_duty[0]});
    // a write without byte lane 0 must leave the register alone
    pstrb <= 4'h0;
    apb(1, A_ACA, 8'h00);
    pstrb <= 4'hf;
    apb(0, A_ACA, 8'h00);
    chk(rd, {24'h0, aca});
    {aca, acb} = '0;
    apb(1, A_ACA, aca);
    apb(1, A_ACB, acb);
    update({8'hff, 8'h00, 8'h55, 8'h01});
    repeat (600) @(posedge core_clk);
    for (int c = 0; c < 4; c++)
      chk(hi_cnt[c], exp_duty[c]);
    // full-scale ramp from zero: 255 updates at one slot, six at 48
    update('0);
    aca = {3'h0, 3'h7, 2'b11};
    apb(1, A_ACA, aca);
    fast = 0;
    for (int n = 1; n <= 255; n++)
    begin
      update({4{8'hff}});
      if (fast == 0 && applied_duty[0] == 8'hff)
        fast = n;
      if (n == 254)
        chk(applied_duty[1], 8'hfe);
    end
    chk(fast, 6);
    chk(applied_duty[1], 8'hff);
    for (int a = 0; a < 2; a++)
    begin
      arm = a ? 8'h3c : 8'h14;
      apb(1, A_DYN, arm);
      for (int c = 0; c < 4; c++)
      begin
        opv[c] = $urandom;
        apb(1, 12'(A_OPP + 4 * c), opv[c]);
      end
      remote_temp <= $urandom;
      @(posedge core_clk);
      alarm_n <= 1'b0;
      repeat (8) @(posedge core_clk);
      for (int c = 0; c < 4; c++)
        chk(op_point[c], arm[2+c] ? remote_temp[c] : opv[c]);
      alarm_n <= 1'b1;
      repeat (4) @(posedge core_clk);
    end
    end_of_test();
  end
endmodule // frl_ramp_limiter_tb
`default_nettype wire
